// >>> core/exec_pkg.sv
// constants, field layouts and carriers for the instruction subset unit
// assumes a 32-bit AHB-Lite slave port with word-only accesses
package exec_pkg;
  localparam int FILE_ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int OFS_W = 12;
  // register byte offsets
  localparam logic [11:0] CMD_OFS = 12'h000;
  localparam logic [11:0] ACC_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] FILE_BASE = 12'h200;
  localparam int FILE_SEL_MSB = 11;
  localparam int FILE_SEL_LSB = 9;
  localparam logic [2:0] FILE_SEL = 3'h1;
  localparam int WORD_LSB = 2;
  // operation codes in the command register
  localparam logic [2:0] OP_CLEAR_FILE = 3'h1;
  localparam logic [2:0] OP_COMPLEMENT_FILE = 3'h2;
  localparam logic [2:0] OP_WATCHDOG_CLEAR = 3'h3;
  localparam logic [2:0] OP_COMPARE_ACC_FILE = 3'h4;
  localparam logic [2:0] OP_DECIMAL_ADJUST = 3'h5;
  localparam logic [2:0] OP_DECREMENT_SKIP_ZERO = 3'h6;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h18;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  // decimal adjust constants
  localparam logic [3:0] NIBBLE_MAX = 4'h9;
  localparam logic [8:0] ADJ_LOW = 9'h006;
  localparam logic [8:0] ADJ_HIGH = 9'h060;
  localparam logic HRESP_OKAY = 1'b0;
  // command register: bits [10:0]
  typedef struct packed {
    logic [6:0] addr;
    logic dest;
    logic [2:0] op;
  } cmd_t;
  // status register: bits [7:0]
  typedef struct packed {
    logic skip_last;
    logic busy;
    logic psc_on_wdt;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic z;
    logic dc;
    logic c;
  } status_t;
endpackage

// >>> core/mcu_instruction_subset_exec.sv
// execution unit for clear/complement file, watchdog clear, compare,
// decimal adjust and decrement-skip-zero, with an AHB-Lite register port
// assumes one bus master, word accesses only, SYS_CLK at 125 MHz
//
// Function
// - clear-file writes zero to the file register and sets Z, one cycle.
// - complement-file inverts the file register, Z follows the inverted value.
// - destination bit 0 writes the accumulator, 1 writes the file register.
// - watchdog clear zeroes watchdog, and prescaler only when assigned to it.
// - watchdog clear sets timeout and power-down flags (active low) to one.
// - compare does file minus accumulator, updates Z and C, stores nothing.
// - decimal adjust turns a binary sum into packed decimal, touches only C.
// - decrement-skip stores file minus one per destination; zero discards next.
// - a skipped instruction becomes a no-op, skipping takes two cycles.
`timescale 1ns/1ns
module mcu_instruction_subset_exec
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // core side
  output logic WDT_CLR,
  output logic PRESCALER_CLR,
  output logic SKIP_NOP,
  output exec_pkg::status_t STATUS
);
  import exec_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} state_t;

  // file minus operand with the no-borrow bit on top
  function automatic logic [8:0] sub_nb(input logic [7:0] a, input logic [7:0] b);
    sub_nb = {1'b0, a} + {1'b0, ~b} + 9'h001;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] file_mem [FILE_DEPTH];
  logic [7:0] acc_q;
  status_t stat_q;
  cmd_t cmd_q;
  state_t st_q;
  logic wdt_clr_q;
  logic psc_clr_q;

  // bus pipeline
  logic dph_q;
  logic ready_q;
  logic write_q;
  logic [OFS_W-1:0] ofs_q;
  logic [31:0] rdata_q;
  logic accept;
  logic commit;
  logic is_file;

  // one wait state for every access, more while an operation runs
  assign HREADYOUT = !dph_q || ready_q;
  assign HRESP = HRESP_OKAY;
  assign HRDATA = rdata_q;
  assign accept = HSEL && HTRANS[1] && HREADY;
  assign commit = dph_q && ready_q;
  assign is_file = ofs_q[FILE_SEL_MSB:FILE_SEL_LSB] == FILE_SEL;

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dph_q <= 1'b0;
      ready_q <= 1'b0;
      write_q <= 1'b0;
      ofs_q <= '0;
    end
    else
    begin
      if (accept)
      begin
        dph_q <= 1'b1;
        write_q <= HWRITE;
        ofs_q <= HADDR[OFS_W-1:0];
      end
      else if (commit)
        dph_q <= 1'b0;
      ready_q <= dph_q && !ready_q && (st_q == ST_IDLE);
    end
  end

  // read data sampled in the wait cycle, so it is a flop at the port
  logic [FILE_ADDR_W-1:0] bus_fidx;
  assign bus_fidx = ofs_q[WORD_LSB +: FILE_ADDR_W];
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= '0;
    else if (dph_q && !ready_q && !write_q)
    begin
      if (is_file)
        rdata_q <= {24'h000000, file_mem[bus_fidx]};
      else if (ofs_q == CMD_OFS)
        rdata_q <= {21'h000000, cmd_q};
      else if (ofs_q == ACC_OFS)
        rdata_q <= {24'h000000, acc_q};
      else if (ofs_q == STAT_OFS)
        rdata_q <= {24'h000000, stat_q};
      else
        rdata_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operation datapath
  logic [7:0] opnd;
  logic [7:0] res;
  logic wr_acc;
  logic wr_file;
  logic z_upd;
  logic c_upd;
  logic c_val;
  logic skip;
  logic wdt_op;
  logic [8:0] diff;
  logic [8:0] daa;

  assign opnd = file_mem[cmd_q.addr];

  always_comb
  begin
    res = BYTE_ZERO;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    z_upd = 1'b0;
    c_upd = 1'b0;
    c_val = 1'b0;
    skip = 1'b0;
    wdt_op = 1'b0;
    diff = '0;
    daa = {1'b0, acc_q};
    case (cmd_q.op)
      OP_CLEAR_FILE:
      begin
        res = BYTE_ZERO;
        wr_file = 1'b1;
        z_upd = 1'b1;
      end
      OP_COMPLEMENT_FILE:
      begin
        res = ~opnd;
        wr_acc = cmd_q.dest == DEST_ACC;
        wr_file = cmd_q.dest == DEST_FILE;
        z_upd = 1'b1;
      end
      OP_WATCHDOG_CLEAR:
        wdt_op = 1'b1;
      OP_COMPARE_ACC_FILE:
      begin
        diff = sub_nb(opnd, acc_q);
        res = diff[7:0];
        z_upd = 1'b1;
        c_upd = 1'b1;
        c_val = diff[8];
      end
      OP_DECIMAL_ADJUST:
      begin
        // low nibble first so its carry ripples into the high test
        if (stat_q.dc || (acc_q[3:0] > NIBBLE_MAX))
          daa = daa + ADJ_LOW;
        if (stat_q.c || daa[8] || (daa[7:4] > NIBBLE_MAX))
          daa = daa + ADJ_HIGH;
        res = daa[7:0];
        wr_acc = 1'b1;
        c_upd = 1'b1;
        c_val = stat_q.c || daa[8];
      end
      OP_DECREMENT_SKIP_ZERO:
      begin
        diff = sub_nb(opnd, BYTE_ONE);
        res = diff[7:0];
        wr_acc = cmd_q.dest == DEST_ACC;
        wr_file = cmd_q.dest == DEST_FILE;
        z_upd = 1'b1;
        skip = diff[7:0] == BYTE_ZERO;
      end
      default:
        res = BYTE_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing: one execute cycle, plus a no-op cycle when skipping
  logic cmd_wr;
  logic exec;
  assign cmd_wr = commit && write_q && (ofs_q == CMD_OFS);
  assign exec = st_q == ST_EXEC;

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      cmd_q <= '0;
    end
    else
    begin
      if (cmd_wr)
        cmd_q <= HWDATA[$bits(cmd_t)-1:0];
      case (st_q)
        ST_IDLE:
          if (cmd_wr)
            st_q <= ST_EXEC;
        ST_EXEC:
          st_q <= skip ? ST_NOP : ST_IDLE;
        ST_NOP:
          st_q <= ST_IDLE;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  assign SKIP_NOP = st_q == ST_NOP;

  // file memory: no reset, contents are software's to initialise
  always_ff @(posedge SYS_CLK)
  begin
    if (exec && wr_file)
      file_mem[cmd_q.addr] <= res;
    else if (commit && write_q && is_file)
      file_mem[bus_fidx] <= HWDATA[7:0];
  end

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      acc_q <= ACC_RST;
    else if (exec && wr_acc)
      acc_q <= res;
    else if (commit && write_q && (ofs_q == ACC_OFS))
      acc_q <= HWDATA[7:0];
  end

  // bus writes never coincide with an execute cycle, the stall sees to that
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      stat_q <= STAT_RST;
    else
    begin
      if (commit && write_q && (ofs_q == STAT_OFS))
      begin
        stat_q.c <= HWDATA[0];
        stat_q.dc <= HWDATA[1];
        stat_q.z <= HWDATA[2];
        stat_q.powerdown_flag_n <= HWDATA[3];
        stat_q.timeout_flag_n <= HWDATA[4];
        stat_q.psc_on_wdt <= HWDATA[5];
      end
      if (exec && z_upd)
        stat_q.z <= res == BYTE_ZERO;
      if (exec && c_upd)
        stat_q.c <= c_val;
      if (exec && wdt_op)
      begin
        stat_q.timeout_flag_n <= 1'b1;
        stat_q.powerdown_flag_n <= 1'b1;
      end
      if (exec)
        stat_q.skip_last <= skip;
      stat_q.busy <= (st_q != ST_IDLE) ? (exec && skip) : cmd_wr;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wdt_clr_q <= 1'b0;
      psc_clr_q <= 1'b0;
    end
    else
    begin
      wdt_clr_q <= exec && wdt_op;
      psc_clr_q <= exec && wdt_op && stat_q.psc_on_wdt;
    end
  end

  assign WDT_CLR = wdt_clr_q;
  assign PRESCALER_CLR = psc_clr_q;
  assign STATUS = stat_q;
endmodule

// >>> bench/exec_properties.sv
// timing properties of the instruction subset unit
// sees only top-level ports: clock, reset and outputs; bound below the module
`timescale 1ns/1ns
module exec_properties
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // watched outputs
  input wire logic HREADYOUT,
  input wire logic WDT_CLR,
  input wire logic PRESCALER_CLR,
  input wire logic SKIP_NOP,
  input wire exec_pkg::status_t STATUS
);
  import exec_pkg::*;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);
  a_psc_needs_wdt: assert property (PRESCALER_CLR |-> WDT_CLR)
    else $error("prescaler clear alone");
  a_psc_when_assigned: assert property
    (WDT_CLR |-> PRESCALER_CLR == STATUS.psc_on_wdt)
    else $error("prescaler clear ignores assignment");
  a_wdt_sets_flags: assert property
    (WDT_CLR |-> STATUS.timeout_flag_n && STATUS.powerdown_flag_n)
    else $error("status flags not set");
  a_wdt_single_pulse: assert property (WDT_CLR |=> !WDT_CLR)
    else $error("watchdog clear too long");
  a_skip_zero_result: assert property
    (SKIP_NOP |-> STATUS.z && STATUS.skip_last)
    else $error("skip without zero result");
  a_skip_two_cycles: assert property
    (SKIP_NOP |-> STATUS.busy ##1 (!SKIP_NOP && !STATUS.busy))
    else $error("skip slot not one cycle");
  a_busy_bounded: assert property (STATUS.busy [*2] |=> !STATUS.busy)
    else $error("operation over two cycles");
  a_skip_after_exec: assert property ($rose(SKIP_NOP) |-> $past(STATUS.busy))
    else $error("skip without execute");
  a_wait_bounded: assert property (!HREADYOUT |-> ##[1:4] HREADYOUT)
    else $error("bus wait too long");
endmodule
bind mcu_instruction_subset_exec exec_properties chk (.SYS_CLK, .RST_B,
  .HREADYOUT, .WDT_CLR, .PRESCALER_CLR, .SKIP_NOP, .STATUS);

// >>> bench/mcu_instruction_subset_exec_tb_top.sv
// random operands through every operation code, checked over the bus
// bench is the only bus master; HREADY follows HREADYOUT
`timescale 1ns/1ns
module mcu_instruction_subset_exec_tb_top;
  import exec_pkg::*;
  logic SYS_CLK, RST_B, HSEL, HWRITE, HREADYOUT, HRESP;
  logic WDT_CLR, PRESCALER_CLR, SKIP_NOP;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [31:0] HADDR, HWDATA, HRDATA;
  status_t STATUS;
  int fail_count, cmp_count, n_wdt, n_psc, n_skip;
  int seed = 32'h2569;
  mcu_instruction_subset_exec uut (.SYS_CLK, .RST_B, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
    .WDT_CLR, .PRESCALER_CLR, .SKIP_NOP, .STATUS);
  initial
  begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK)
  begin
    n_wdt += WDT_CLR;
    n_psc += PRESCALER_CLR;
    n_skip += SKIP_NOP;
  end
  ////////////////////////////////////////
  task report_and_stop;
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  // look at ready off the edge so no race with its update
  task automatic wt(output logic [31:0] r);
    int n;
    n = 0;
    do
    begin
      @(negedge SYS_CLK);
      n++;
    end
    while (HREADYOUT !== 1'b1 && n < 40);
    if (HREADYOUT !== 1'b1)
    begin
      fail_count++;
      report_and_stop;
    end
    r = HRDATA;
    chk("hresp", {7'h0, HRESP_OKAY}, {7'h0, HRESP});
    @(posedge SYS_CLK);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    HSEL <= 1'b1;
    HADDR <= {20'h0, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    wt(r);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wt(r);
  endtask
  ////////////////////////////////////////
  function automatic void model(input logic [2:0] op, input logic dst,
    input logic [7:0] v, inout logic [7:0] ac, inout logic [7:0] f, inout status_t st);
    logic [8:0] t;
    logic [7:0] res;
    res = (op == OP_COMPLEMENT_FILE) ? ~v : v - 8'h01;
    if (op == OP_CLEAR_FILE)
    begin
      f = 8'h00;
      st.z = 1'b1;
    end
    if (op == OP_COMPLEMENT_FILE || op == OP_DECREMENT_SKIP_ZERO)
    begin
      st.z = (res == 8'h00);
      if (dst == DEST_FILE)
        f = res;
      else
        ac = res;
    end
    if (op == OP_WATCHDOG_CLEAR)
    begin
      st.timeout_flag_n = 1'b1;
      st.powerdown_flag_n = 1'b1;
    end
    if (op == OP_COMPARE_ACC_FILE)
    begin
      st.z = (v == ac);
      st.c = (v >= ac);
    end
    if (op == OP_DECIMAL_ADJUST)
    begin
      t = {1'b0, ac} + ((st.dc || ac[3:0] > 4'h9) ? 9'h006 : 9'h000);
      if (st.c || t[8] || t[7:4] > 4'h9)
        t = t + 9'h060;
      ac = t[7:0];
      st.c = st.c | t[8];
    end
  endfunction
  ////////////////////////////////////////
  initial
  begin
    logic [31:0] r;
    logic [11:0] fa;
    logic [7:0] v, ac, f;
    logic [6:0] a;
    logic [2:0] op;
    logic dst;
    status_t st;
    int e_wdt, e_psc, e_skip;
    {HSEL, HWRITE, HTRANS, HADDR, HWDATA, RST_B} <= '0;
    HSIZE <= 3'h2;
    repeat (4) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    for (int i = 0; i < 64; i++)
    begin
      op = i[2:0];
      dst = 1'($random(seed));
      a = 7'($random(seed));
      v = 8'($random(seed));
      ac = 8'($random(seed));
      st = status_t'(8'($random(seed)) & 8'h3F);
      // early passes force skip to zero and equal compare
      if (i < 16)
        v = (i < 8) ? 8'h01 : ac;
      if (i == 3)
        a = 7'h7F;
      // decimal corner: low nibble over nine, no carries coming in
      if (i == 13)
      begin
        ac = 8'h4D;
        st.dc = 1'b0;
        st.c = 1'b0;
      end
      fa = FILE_BASE + {3'h0, a, 2'b00};
      bus(1'b1, fa, {24'h0, v}, r);
      bus(1'b1, ACC_OFS, {24'h0, ac}, r);
      bus(1'b1, STAT_OFS, {24'h0, st}, r);
      e_wdt += (op == OP_WATCHDOG_CLEAR);
      e_psc += (op == OP_WATCHDOG_CLEAR && st.psc_on_wdt);
      e_skip += (op == OP_DECREMENT_SKIP_ZERO && v == 8'h01);
      f = v;
      model(op, dst, v, ac, f, st);
      bus(1'b1, CMD_OFS, {21'h0, a, dst, op}, r);
      bus(1'b0, ACC_OFS, 32'h0, r);
      chk("acc", ac, r[7:0]);
      if (i == 13)
        chk("daa_corner", 8'h53, r[7:0]);
      bus(1'b0, fa, 32'h0, r);
      chk("file", f, r[7:0]);
      bus(1'b0, STAT_OFS, 32'h0, r);
      chk("status", {1'b0, st[6:0]}, {1'b0, r[6:0]});
      if (op == OP_DECREMENT_SKIP_ZERO)
        chk("skip_last", {7'h0, v == 8'h01}, {7'h0, r[7]});
    end
    bus(1'b1, 12'h100, 32'hFF, r);
    bus(1'b0, 12'h100, 32'h0, r);
    chk("unmapped", 8'h00, r[7:0]);
    chk("wdt_pulses", 8'(e_wdt), 8'(n_wdt));
    chk("psc_pulses", 8'(e_psc), 8'(n_psc));
    chk("nop_slots", 8'(e_skip), 8'(n_skip));
    report_and_stop;
  end
endmodule
